// [bench/csro_clock_ctrl_tb.sv]
// Self-checking testbench of the clock select and reference output block.
`timescale 1ns/1ps

module csro_clock_ctrl_tb;

    // Design inputs and outputs.
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic config_pll_enable = 1'b0;
    logic config_sysclk_out_enable = 1'b0;
    logic config_crystal_mode = 1'b0;
    logic timer1_osc_enable = 1'b0;
    logic sleep = 1'b0;
    csro_pkg::csro_osc_raw_t osc_raw = 8'h00;
    logic pll_enable;
    logic [3:0] internal_freq_select;
    csro_pkg::csro_osc_t internal_osc_source;
    logic hf_pll_32mhz;
    csro_pkg::csro_sys_t system_clock_source;
    logic [5:0] freq_trim;
    logic refclk_internal;
    logic refclk_out_pin_o;
    logic refclk_out_pin_oe;
    logic refclk_slew_limit;
    // Counts kept by the external part.
    int ext_high;
    int ext_rise;
    // Bench bookkeeping.
    int failures = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] rd_q;
    logic [15:0] exp_q;
    int h0;
    int h1;
    int hi;
    int per;

    // The clock period is 100 ns.
    always #50 clk = ~clk;

    csro_clock_ctrl #(.DIV_W(3)) u_csro_clock_ctrl (
        .clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .config_pll_enable(config_pll_enable),
        .config_sysclk_out_enable(config_sysclk_out_enable),
        .config_crystal_mode(config_crystal_mode),
        .timer1_osc_enable(timer1_osc_enable), .sleep(sleep),
        .osc_raw(osc_raw), .pll_enable(pll_enable),
        .internal_freq_select(internal_freq_select),
        .internal_osc_source(internal_osc_source),
        .hf_pll_32mhz(hf_pll_32mhz),
        .system_clock_source(system_clock_source), .freq_trim(freq_trim),
        .refclk_internal(refclk_internal),
        .refclk_out_pin_o(refclk_out_pin_o),
        .refclk_out_pin_oe(refclk_out_pin_oe),
        .refclk_slew_limit(refclk_slew_limit)
    );

    csro_ext_device u_csro_ext_device (
        .clk(clk), .pin_o(refclk_out_pin_o), .pin_oe(refclk_out_pin_oe),
        .high_cycles(ext_high), .rises(ext_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // One-cycle register read; the data stand in the following cycle.
    task automatic rd(input logic [1:0] a);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        rd_q = reg_rdata;
    endtask

    // Counts high cycles of the internal reference over n cycles.
    task automatic count_ref(input int n, output int h);
        h = 0;
        repeat (n)
        begin
            @(negedge clk);
            h += int'(refclk_internal);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // A hang is cut short well beyond the expected run length.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            close_out();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main test sequence.
    initial
    begin
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        // Reset values of registers and outputs.
        rd(csro_pkg::ADDR_OSC_CONTROL);
        chk(16'(rd_q), 16'h0038);
        chk(16'(internal_freq_select), 16'h0007);
        rd(csro_pkg::ADDR_OSC_TUNING);
        chk(16'(rd_q), 16'h0000);
        rd(csro_pkg::ADDR_REFCLK_CONTROL);
        chk(16'(rd_q), 16'h0030);
        chk(16'(refclk_out_pin_oe), 16'h0000);
        $display("test reset values done");
        // Unimplemented bits read zero; the low trim bits read back and the top trim bit reaches the port.
        wr(csro_pkg::ADDR_OSC_CONTROL, 8'hFF);
        rd(csro_pkg::ADDR_OSC_CONTROL);
        chk(16'(rd_q), 16'h00FB);
        wr(csro_pkg::ADDR_OSC_TUNING, 8'hDF);
        rd(csro_pkg::ADDR_OSC_TUNING);
        chk(16'(rd_q), 16'h001F);
        wr(csro_pkg::ADDR_OSC_TUNING, 8'h20);
        rd(csro_pkg::ADDR_OSC_TUNING);
        chk(16'(freq_trim), 16'h0020);
        $display("test read-as-zero done");
        // PLL enable from the soft bit and from the config force.
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            config_pll_enable <= i[1];
            wr(csro_pkg::ADDR_OSC_CONTROL, {i[0], 4'hE, 3'h0});
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk(16'(pll_enable), 16'(i[0] | i[1]));
            chk(16'(hf_pll_32mhz), 16'(i[0] | i[1]));
        end
        $display("test pll enable done");
        // Every frequency select code and every clock select code.
        for (int c = 0; c < 16; c++)
        begin
            wr(csro_pkg::ADDR_OSC_CONTROL, {1'b0, 4'(c), 1'b0, 2'(c)});
            repeat (2) @(posedge clk);
            @(negedge clk);
            chk(16'(internal_freq_select), 16'(c));
            if (c >= 8 || c == 3)
                exp_q = 16'(csro_pkg::CSRO_OSC_HF);
            else if (c < 2)
                exp_q = 16'(csro_pkg::CSRO_OSC_LF);
            else
                exp_q = 16'(csro_pkg::CSRO_OSC_MF);
            chk(16'(internal_osc_source), exp_q);
            exp_q = (c % 4 >= 2) ? 16'(csro_pkg::CSRO_SYS_INTERNAL) :
                (c % 4 == 1) ? 16'(csro_pkg::CSRO_SYS_TIMER1) :
                16'(csro_pkg::CSRO_SYS_CONFIG);
            chk(16'(system_clock_source), exp_q);
        end
        $display("test frequency and source select done");
        // Status bits follow the raw reports, one at a time.
        for (int b = 0; b < 10; b++)
        begin
            @(posedge clk);
            timer1_osc_enable <= (b != 8);
            osc_raw <= (b < 8) ? 8'(1 << b) : 8'h00;
            repeat (3) @(posedge clk);
            rd(csro_pkg::ADDR_OSC_STATUS);
            exp_q = (b < 8) ? 16'(1 << b) : 16'h0000;
            if (b == 8)
                exp_q = 16'h0080;
            chk(16'(rd_q), exp_q);
        end
        $display("test status done");
        // Every divider and duty setting, on the line and on the pin.
        for (int dv = 0; dv < 8; dv++)
            for (int dc = 0; dc < 4; dc++)
            begin
                wr(csro_pkg::ADDR_REFCLK_CONTROL, 8'h20);
                wr(csro_pkg::ADDR_REFCLK_CONTROL,
                    {3'b111, 2'(dc), 3'(dv)});
                per = 2 << dv;
                hi = (dc == 0) ? 0 : (dv == 0) ? 1 : (per / 4) * dc;
                repeat (per + 3) @(posedge clk);
                h0 = ext_high;
                count_ref(2 * per, h1);
                chk(16'(h1), 16'(2 * hi));
                chk(16'(ext_high - h0), 16'(2 * hi));
            end
        $display("test divider and duty done");
        // Output enable clear keeps the pin undriven; disable stops all.
        wr(csro_pkg::ADDR_REFCLK_CONTROL, 8'hA9);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(16'(refclk_out_pin_oe), 16'h0000);
        wr(csro_pkg::ADDR_REFCLK_CONTROL, 8'h29);
        // The disable acts one edge after the write lands.
        @(posedge clk);
        count_ref(16, h1);
        chk(16'(h1), 16'h0000);
        // Clock-out option puts a quarter clock on the pin.
        wr(csro_pkg::ADDR_REFCLK_CONTROL, 8'hC9);
        @(posedge clk);
        config_sysclk_out_enable <= 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        h0 = ext_rise;
        repeat (16) @(posedge clk);
        @(negedge clk);
        chk(16'(ext_rise - h0), 16'h0004);
        // Crystal mode keeps the pin free; the line still runs.
        @(posedge clk);
        config_crystal_mode <= 1'b1;
        repeat (3) @(posedge clk);
        h0 = ext_high;
        count_ref(16, h1);
        chk(16'(ext_high - h0), 16'h0000);
        chk(16'(h1), 16'h0004);
        $display("test pin conflicts done");
        // Sleep freezes the line and the pin.
        @(posedge clk);
        config_crystal_mode <= 1'b0;
        config_sysclk_out_enable <= 1'b0;
        repeat (5) @(posedge clk);
        sleep <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        exp_q = {14'h0, refclk_internal, refclk_out_pin_o};
        h0 = ext_rise;
        repeat (20) @(posedge clk);
        @(negedge clk);
        chk({14'h0, refclk_internal, refclk_out_pin_o}, exp_q);
        chk(16'(ext_rise - h0), 16'h0000);
        @(posedge clk);
        sleep <= 1'b0;
        count_ref(16, h1);
        chk(16'(h1), 16'h0004);
        $display("test sleep done");
        chk(16'(refclk_slew_limit), 16'h0000);
        // A second reset in mid-run restores the defaults.
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk(16'(refclk_out_pin_oe), 16'h0000);
        chk(16'(refclk_slew_limit), 16'h0001);
        rd(csro_pkg::ADDR_REFCLK_CONTROL);
        chk(16'(rd_q), 16'h0030);
        rd(csro_pkg::ADDR_OSC_CONTROL);
        chk(16'(rd_q), 16'h0038);
        $display("test second reset done");
        close_out();
    end

endmodule

// [bench/csro_ext_device.sv]
// External part that takes its clock from the reference output pin.
`timescale 1ns/1ps

module csro_ext_device (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe,
    output int high_cycles,
    output int rises
);

    // Level at the part's clock input; a pull-down holds it low undriven.
    logic pin_level;
    // Level seen at the previous edge, for edge detection.
    logic last_q = 1'b0;
    // Running counts of high cycles and rising edges.
    int high_q = 0;
    int rise_q = 0;

    assign pin_level = pin_oe ? pin_o : 1'b0;
    assign high_cycles = high_q;
    assign rises = rise_q;

    ////////////////////////////////////////////////////////////////////////
    // The part samples its clock input once per system clock.
    always @(posedge clk)
    begin
        high_q <= high_q + int'(pin_level);
        rise_q <= rise_q + int'(pin_level & ~last_q);
        last_q <= pin_level;
    end

endmodule

// [hdl/csro_clock_ctrl.sv]
// Oscillator select, status and tuning registers with the reference clock.
//
// Operation
// - Config PLL enable forces PLL always on.
// - Otherwise soft PLL bit enables the PLL.
// - Frequency select picks oscillator and rate.
// - Frequency select resets to 0111, 500 kHz.
// - Code 1110 gives 8 MHz, 32 MHz with PLL.
// - System clock select chooses clock source.
// - Unimplemented control and tuning bits read zero.
// - Timer1 ready reads one when disabled.
// - PLL ready bit shows PLL readiness.
// - Startup status shows configured clock running.
// - HF, MF, LF ready bits report readiness.
// - HF locked means at least 2% accurate.
// - HF stable means at least 0.5% accurate.
// - Six-bit signed trim, resets to zero.
// - Generator runs from sysclk only when enabled.
// - Pin gets refclk only when output enabled.
// - Three-bit divider offers eight ratios.
// - Undivided duty follows source unless zero.
// - Reset disables generator and restores registers.
// - Crystal modes keep refclk off the pin.
// - Clock-out option puts sysclk/4 on pin.
// - Sleep freezes generator and its outputs.
// - Divider is power of two, 1 to 128.
// - Duty field gives 0, 25, 50, 75 percent.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/1ps

module csro_clock_ctrl #(
    parameter int DIV_W = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic config_pll_enable,
    input wire logic config_sysclk_out_enable,
    input wire logic config_crystal_mode,
    input wire logic timer1_osc_enable,
    input wire logic sleep,
    input wire csro_pkg::csro_osc_raw_t osc_raw,
    output logic pll_enable,
    output logic [3:0] internal_freq_select,
    output csro_pkg::csro_osc_t internal_osc_source,
    output logic hf_pll_32mhz,
    output csro_pkg::csro_sys_t system_clock_source,
    output logic [5:0] freq_trim,
    output logic refclk_internal,
    output logic refclk_out_pin_o,
    output logic refclk_out_pin_oe,
    output logic refclk_slew_limit
);

    ////////////////////////////////////////////////////////////////////////
    // Registers and derived fields.

    // Oscillator control register, bit 2 held at zero.
    logic [7:0] osc_control_q;
    // Oscillator tuning register, bits 7 and 6 held at zero.
    logic [7:0] osc_tuning_q;
    // Reference clock control register.
    logic [7:0] refclk_control_q;
    // Registered status image.
    csro_pkg::csro_status_t status_q;
    // Read data register.
    logic [7:0] rdata_q;

    // Fields pulled out of the control registers.
    logic soft_pll_enable;
    logic [3:0] ifs_field;
    logic [1:0] scs_field;
    logic refclk_module_enable;
    logic refclk_output_enable;
    logic [1:0] duty_field;
    logic [DIV_W-1:0] div_field;

    assign soft_pll_enable = osc_control_q[csro_pkg::OSC_CTL_PLL_BIT];
    assign ifs_field = osc_control_q[csro_pkg::OSC_CTL_IFS_LSB +: 4];
    assign scs_field = osc_control_q[csro_pkg::OSC_CTL_SCS_LSB +: 2];
    assign refclk_module_enable = refclk_control_q[csro_pkg::REF_EN_BIT];
    assign refclk_output_enable = refclk_control_q[csro_pkg::REF_OE_BIT];
    assign duty_field = refclk_control_q[csro_pkg::REF_DUTY_LSB +: 2];
    assign div_field = refclk_control_q[csro_pkg::REF_DIV_LSB +: DIV_W];

    ////////////////////////////////////////////////////////////////////////
    // Register writes.

    // Oscillator control: masked write keeps the unused bit at zero.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            osc_control_q <= csro_pkg::OSC_CONTROL_RESET;
        end
        else if (reg_write && reg_addr == csro_pkg::ADDR_OSC_CONTROL)
        begin
            osc_control_q <= reg_wdata & csro_pkg::OSC_CONTROL_MASK;
        end
    end

    // Oscillator tuning: only the six trim bits are stored.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            osc_tuning_q <= csro_pkg::OSC_TUNING_RESET;
        end
        else if (reg_write && reg_addr == csro_pkg::ADDR_OSC_TUNING)
        begin
            osc_tuning_q <= reg_wdata & csro_pkg::OSC_TUNING_MASK;
        end
    end

    // Reference clock control: all eight bits are writable.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            refclk_control_q <= csro_pkg::REFCLK_CONTROL_RESET;
        end
        else if (reg_write && reg_addr == csro_pkg::ADDR_REFCLK_CONTROL)
        begin
            refclk_control_q <= reg_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status and read port.

    // Status is sampled every cycle from the oscillator reports.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            status_q <= '0;
        end
        else
        begin
            status_q.timer1_osc_ready <= timer1_osc_enable ?
                osc_raw.timer1_ready_raw : 1'b1;
            status_q.pll_ready <= osc_raw.pll_locked;
            status_q.startup_status <= osc_raw.running_config_clock;
            status_q.hf_osc_ready <= osc_raw.hf_ready;
            status_q.mf_osc_ready <= osc_raw.mf_ready;
            status_q.lf_osc_ready <= osc_raw.lf_ready;
            status_q.hf_osc_locked <= osc_raw.hf_locked;
            status_q.hf_osc_stable <= osc_raw.hf_stable;
        end
    end

    // Read data stand for the one cycle after the read strobe.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            rdata_q <= '0;
        end
        else if (reg_read)
        begin
            case (reg_addr)
                csro_pkg::ADDR_OSC_CONTROL: rdata_q <= osc_control_q;
                csro_pkg::ADDR_OSC_STATUS: rdata_q <= status_q;
                csro_pkg::ADDR_OSC_TUNING: rdata_q <= osc_tuning_q;
                csro_pkg::ADDR_REFCLK_CONTROL: rdata_q <= refclk_control_q;
                default: rdata_q <= '0;
            endcase
        end
        else
        begin
            rdata_q <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator steering outputs.

    // PLL, source and rate steering toward the oscillator block.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            pll_enable <= 1'b0;
            internal_osc_source <= csro_pkg::CSRO_OSC_MF;
            hf_pll_32mhz <= 1'b0;
            system_clock_source <= csro_pkg::CSRO_SYS_CONFIG;
        end
        else
        begin
            pll_enable <= config_pll_enable | soft_pll_enable;
            if (ifs_field[3:1] == 3'b000)
            begin
                internal_osc_source <= csro_pkg::CSRO_OSC_LF;
            end
            else if (ifs_field == 4'b0011 || ifs_field[3])
            begin
                internal_osc_source <= csro_pkg::CSRO_OSC_HF;
            end
            else
            begin
                internal_osc_source <= csro_pkg::CSRO_OSC_MF;
            end
            hf_pll_32mhz <= (ifs_field == csro_pkg::IFS_HF_8MHZ) &&
                (config_pll_enable | soft_pll_enable);
            if (scs_field[1])
            begin
                system_clock_source <= csro_pkg::CSRO_SYS_INTERNAL;
            end
            else if (scs_field[0])
            begin
                system_clock_source <= csro_pkg::CSRO_SYS_TIMER1;
            end
            else
            begin
                system_clock_source <= csro_pkg::CSRO_SYS_CONFIG;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reference clock generator.

    // Settings in use for the current output period.
    logic [DIV_W-1:0] div_live_q;
    logic [1:0] duty_live_q;
    // Cycle position inside the output period.
    logic [7:0] phase_q;
    // Period length and high time of the live settings.
    logic [8:0] period_len;
    logic [8:0] high_len;
    // Last cycle of the period.
    logic period_end;
    // Quarter-rate system clock count for the clock-out option.
    logic [1:0] quarter_q;

    // The base clock is clk halved, so undivided output is a 50% clock.
    always_comb
    begin
        period_len = 9'(2) << div_live_q;
        if (duty_live_q == 2'b00)
        begin
            high_len = '0;
        end
        else if (div_live_q == '0)
        begin
            high_len = 9'(1);
        end
        else
        begin
            high_len = 9'((period_len >> 2) * duty_live_q);
        end
        period_end = (9'(phase_q) == period_len - 9'(1));
    end

    // Period counter; frozen in sleep, cleared while disabled.
    always_ff @(posedge clk)
    begin
        if (reset || !refclk_module_enable)
        begin
            phase_q <= '0;
            div_live_q <= div_field;
            duty_live_q <= duty_field;
        end
        else if (!sleep)
        begin
            if (period_end)
            begin
                phase_q <= '0;
                div_live_q <= div_field;
                duty_live_q <= duty_field;
            end
            else
            begin
                phase_q <= phase_q + 8'(1);
            end
        end
    end

    // Reference output level for the modulator and the pin.
    always_ff @(posedge clk)
    begin
        if (reset || !refclk_module_enable)
        begin
            refclk_internal <= 1'b0;
        end
        else if (!sleep)
        begin
            refclk_internal <= period_end ? (duty_field != 2'b00) :
                (9'(phase_q) + 9'(1) < high_len);
        end
    end

    // System clock divided by four; stops with the clock in sleep.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            quarter_q <= '0;
        end
        else if (!sleep)
        begin
            quarter_q <= quarter_q + 2'(1);
        end
    end

    // Pin multiplexer: crystal use, then clock-out, then reference.
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            refclk_out_pin_o <= 1'b0;
            refclk_out_pin_oe <= 1'b0;
            refclk_slew_limit <= 1'b1;
        end
        else if (!sleep)
        begin
            refclk_slew_limit <= refclk_control_q[csro_pkg::REF_SLEW_BIT];
            if (config_crystal_mode)
            begin
                refclk_out_pin_o <= 1'b0;
                refclk_out_pin_oe <= 1'b0;
            end
            else if (config_sysclk_out_enable)
            begin
                refclk_out_pin_o <= quarter_q[1];
                refclk_out_pin_oe <= 1'b1;
            end
            else if (refclk_output_enable && refclk_module_enable)
            begin
                refclk_out_pin_o <= period_end ? (duty_field != 2'b00) :
                    (9'(phase_q) + 9'(1) < high_len);
                refclk_out_pin_oe <= 1'b1;
            end
            else
            begin
                refclk_out_pin_o <= 1'b0;
                refclk_out_pin_oe <= 1'b0;
            end
        end
    end

    // Direct register outputs.
    assign reg_rdata = rdata_q;
    assign internal_freq_select = ifs_field;
    assign freq_trim = osc_tuning_q[5:0];

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    // A write to control; at the next edge bit 2 must hold zero.
    sequence s_ctl_write;
        reg_write && reg_addr == csro_pkg::ADDR_OSC_CONTROL;
    endsequence

    a_pll_forced: assert property (@(posedge clk) disable iff (reset)
        config_pll_enable |=> pll_enable)
        else $error("PLL not forced on by config bit");

    a_pll_soft: assert property (@(posedge clk) disable iff (reset)
        !config_pll_enable |=> pll_enable == $past(soft_pll_enable))
        else $error("PLL enable does not follow soft bit");

    a_osc_lf_code: assert property (@(posedge clk) disable iff (reset)
        ifs_field[3:1] == 3'b000 |=>
        internal_osc_source == csro_pkg::CSRO_OSC_LF)
        else $error("LF oscillator not chosen");

    // Checked one edge after a reset edge, so the first edge is safe.
    a_ifs_reset: assert property (@(posedge clk)
        reset |=> ifs_field == 4'b0111)
        else $error("frequency select reset value wrong");

    a_ctl_bit2_zero: assert property (@(posedge clk) disable iff (reset)
        s_ctl_write |=> osc_control_q[2] == 1'b0 && freq_trim[5:0] ==
        osc_tuning_q[5:0] && osc_tuning_q[7:6] == 2'b00)
        else $error("unimplemented bits not zero");

    a_t1_ready_off: assert property (@(posedge clk) disable iff (reset)
        !timer1_osc_enable ##1 reg_read &&
        reg_addr == csro_pkg::ADDR_OSC_STATUS |=> reg_rdata[7])
        else $error("Timer1 ready not one while disabled");

    a_sys_source: assert property (@(posedge clk) disable iff (reset)
        scs_field == 2'b01 |=>
        system_clock_source == csro_pkg::CSRO_SYS_TIMER1)
        else $error("Timer1 source not selected");

    a_ref_disabled: assert property (@(posedge clk) disable iff (reset)
        !refclk_module_enable |=> !refclk_internal)
        else $error("reference runs while disabled");

    a_pin_crystal: assert property (@(posedge clk) disable iff (reset)
        config_crystal_mode && !sleep |=> !refclk_out_pin_oe)
        else $error("pin driven in crystal mode");

    a_sleep_hold: assert property (@(posedge clk) disable iff (reset)
        sleep && refclk_module_enable |=> $stable(refclk_internal) &&
        $stable(phase_q))
        else $error("generator moved in sleep");

    // High in the first of four cycles, low in the other three.
    a_div2_quarter: assert property (@(posedge clk) disable iff (reset)
        refclk_module_enable && !sleep && div_live_q == 3'(1) &&
        duty_live_q == 2'b01 && div_field == 3'(1) &&
        duty_field == 2'b01 && period_end ##1 (!sleep &&
        refclk_module_enable)[*4] |-> $past(refclk_internal, 3) &&
        !$past(refclk_internal, 2) && !$past(refclk_internal, 1) &&
        !refclk_internal)
        else $error("25 percent duty wrong at divide by two");

endmodule

// [pkg/csro_pkg.sv]
// Package holding constants and types of the clock select and reference output block.
package csro_pkg;

    // Register indices on the plain register port.
    localparam logic [1:0] ADDR_OSC_CONTROL = 2'h0;
    localparam logic [1:0] ADDR_OSC_STATUS = 2'h1;
    localparam logic [1:0] ADDR_OSC_TUNING = 2'h2;
    localparam logic [1:0] ADDR_REFCLK_CONTROL = 2'h3;

    // Reset values of the writable registers.
    localparam logic [7:0] OSC_CONTROL_RESET = 8'h38;
    localparam logic [7:0] OSC_TUNING_RESET = 8'h00;
    localparam logic [7:0] REFCLK_CONTROL_RESET = 8'h30;

    // Field positions in the oscillator control register.
    localparam int OSC_CTL_PLL_BIT = 7;
    localparam int OSC_CTL_IFS_LSB = 3;
    localparam int OSC_CTL_SCS_LSB = 0;

    // Writable bits of the control and tuning registers.
    localparam logic [7:0] OSC_CONTROL_MASK = 8'hFB;
    localparam logic [7:0] OSC_TUNING_MASK = 8'h3F;

    // Field positions in the reference clock control register.
    localparam int REF_EN_BIT = 7;
    localparam int REF_OE_BIT = 6;
    localparam int REF_SLEW_BIT = 5;
    localparam int REF_DUTY_LSB = 3;
    localparam int REF_DIV_LSB = 0;

    // Frequency select code that quadruples to the top rate with the PLL.
    localparam logic [3:0] IFS_HF_8MHZ = 4'hE;

    // Internal oscillator that a frequency select code uses.
    typedef enum logic [1:0] {CSRO_OSC_LF, CSRO_OSC_MF, CSRO_OSC_HF} csro_osc_t;

    // Source of the system clock.
    typedef enum logic [1:0] {CSRO_SYS_CONFIG, CSRO_SYS_TIMER1,
        CSRO_SYS_INTERNAL} csro_sys_t;

    // Raw readiness reports from the analog oscillators and timers.
    typedef struct packed {
        logic timer1_ready_raw;
        logic pll_locked;
        logic running_config_clock;
        logic hf_ready;
        logic hf_locked;
        logic mf_ready;
        logic lf_ready;
        logic hf_stable;
    } csro_osc_raw_t;

    // Status register image, bit 7 first.
    typedef struct packed {
        logic timer1_osc_ready;
        logic pll_ready;
        logic startup_status;
        logic hf_osc_ready;
        logic hf_osc_locked;
        logic mf_osc_ready;
        logic lf_osc_ready;
        logic hf_osc_stable;
    } csro_status_t;

endpackage
